// [rtl/datapath_pkg.sv]
// constants and types shared by the rotate, subtract and skip datapath
// Summary of operation
// - rotate left via flag into work register
// - rotate right, bit 0 wraps, flags kept
// - rotate right via flag back to memory
// - rotate right via flag into work register
// - work minus operand minus inverted flag
// - borrow subtract result written to memory
// - bit-out flag means no borrow
// - subtracts update all six arithmetic flags
// - decrement memory, skip when zero
// - to-work inc/dec writes work only
// - increment memory, skip when zero
// - skip costs a dummy second cycle
// - set byte or bit, flags kept
// - skip when byte or bit nonzero
// - swap nibbles in place or to work
// - skip when memory byte is zero
`default_nettype none
package datapath_pkg;
	localparam int DATA_W = 8;
	localparam int NIBBLE_W = 4;
	localparam int BIT_SEL_W = 3;
	localparam int MSB_POS = 7;
	localparam int LSB_POS = 0;
	localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
	localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;

	typedef enum logic [4:0] {
		op_nop,
		op_rotate_left_thru_flag_to_work,
		op_rotate_right,
		op_rotate_right_to_work,
		op_rotate_right_thru_flag,
		op_rotate_right_thru_flag_to_work,
		op_subtract_with_borrow,
		op_subtract_with_borrow_imm,
		op_subtract_with_borrow_to_mem,
		op_minus,
		op_minus_imm,
		op_minus_to_mem,
		op_dec_skip_zero,
		op_dec_skip_zero_to_work,
		op_inc_skip_zero,
		op_inc_skip_zero_to_work,
		op_set_byte,
		op_set_bit,
		op_skip_if_nonnull,
		op_skip_if_nonnull_bit,
		op_nibble_exchange,
		op_nibble_exchange_to_work,
		op_skip_if_null,
		op_skip_if_null_to_work
	} op_t;

	typedef enum logic {
		st_exec,
		st_dummy
	} seq_state_t;
endpackage
`default_nettype wire

// [rtl/borrow_subtract.sv]
// eight-bit subtractor with borrow, half borrow and overflow
`timescale 1ns/10ps
`default_nettype none
module borrow_subtract
	import datapath_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input wire logic [WIDTH-1:0] minuend,
	input wire logic [WIDTH-1:0] subtrahend,
	input wire logic borrow_in,
	output logic [WIDTH-1:0] diff,
	output logic not_borrow,
	output logic half_not_borrow,
	output logic overflow
);
	logic [WIDTH:0] wide;
	logic [NIBBLE_W:0] low;
	logic [WIDTH:0] borrow_ext;
	logic [NIBBLE_W:0] borrow_low;

	assign borrow_ext = {{WIDTH{1'b0}}, borrow_in};
	assign borrow_low = {{NIBBLE_W{1'b0}}, borrow_in};
	assign wide = {1'b0, minuend} - {1'b0, subtrahend} - borrow_ext;
	assign low = {1'b0, minuend[NIBBLE_W-1:0]} - {1'b0, subtrahend[NIBBLE_W-1:0]} - borrow_low;
	assign diff = wide[WIDTH-1:0];
	// negative result clears the flag, zero or positive sets it
	assign not_borrow = ~wide[WIDTH];
	assign half_not_borrow = ~low[NIBBLE_W];
	assign overflow = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1]) & (minuend[WIDTH-1] ^ diff[WIDTH-1]);
endmodule // borrow_subtract
`default_nettype wire

// [rtl/mcu_rotate_sub_skip_datapath.sv]
// rotate, subtract, skip, set and swap execution datapath
`timescale 1ns/10ps
`default_nettype none
module mcu_rotate_sub_skip_datapath
	import datapath_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic op_valid,
	input wire op_t op,
	input wire logic [DATA_W-1:0] mem_rdata,
	input wire logic [DATA_W-1:0] imm,
	input wire logic [BIT_SEL_W-1:0] bit_sel,
	input wire logic bit_out_in,
	input wire logic multibyte_null_in,
	input wire logic work_load,
	input wire logic [DATA_W-1:0] work_load_data,
	output logic op_ready,
	output logic [DATA_W-1:0] work_register,
	output logic mem_we,
	output logic [DATA_W-1:0] mem_wdata,
	output logic bit_out_we,
	output logic arith_flags_we,
	output logic bit_out_flag,
	output logic signed_overflow_flag,
	output logic zero_flag,
	output logic half_nibble_flag,
	output logic sign_compare_flag,
	output logic multibyte_null_flag,
	output logic skip
);
	seq_state_t state_q;
	seq_state_t state_d;
	logic [DATA_W-1:0] work_q;
	logic [DATA_W-1:0] work_d;
	logic [DATA_W-1:0] mem_wdata_q;
	logic mem_we_q;
	logic skip_q;
	logic bit_out_we_q;
	logic arith_we_q;
	logic bit_out_q;
	logic overflow_q;
	logic zero_q;
	logic half_q;
	logic sign_cmp_q;
	logic multi_null_q;

	// operation decode
	logic take;
	logic is_rot_l_tw;
	logic is_rot_r;
	logic is_rot_r_tw;
	logic is_rot_rc;
	logic is_rot_rc_tw;
	logic is_sub_b;
	logic is_sub_b_imm;
	logic is_sub_b_mem;
	logic is_sub;
	logic is_sub_imm;
	logic is_sub_mem;
	logic is_dec;
	logic is_dec_tw;
	logic is_inc;
	logic is_inc_tw;
	logic is_set_byte;
	logic is_set_bit;
	logic is_nonnull;
	logic is_nonnull_bit;
	logic is_swap;
	logic is_swap_tw;
	logic is_null;
	logic is_null_tw;

	assign op_ready = (state_q == st_exec);
	assign take = op_valid & op_ready;
	assign is_rot_l_tw = (op == op_rotate_left_thru_flag_to_work);
	assign is_rot_r = (op == op_rotate_right);
	assign is_rot_r_tw = (op == op_rotate_right_to_work);
	assign is_rot_rc = (op == op_rotate_right_thru_flag);
	assign is_rot_rc_tw = (op == op_rotate_right_thru_flag_to_work);
	assign is_sub_b = (op == op_subtract_with_borrow);
	assign is_sub_b_imm = (op == op_subtract_with_borrow_imm);
	assign is_sub_b_mem = (op == op_subtract_with_borrow_to_mem);
	assign is_sub = (op == op_minus);
	assign is_sub_imm = (op == op_minus_imm);
	assign is_sub_mem = (op == op_minus_to_mem);
	assign is_dec = (op == op_dec_skip_zero);
	assign is_dec_tw = (op == op_dec_skip_zero_to_work);
	assign is_inc = (op == op_inc_skip_zero);
	assign is_inc_tw = (op == op_inc_skip_zero_to_work);
	assign is_set_byte = (op == op_set_byte);
	assign is_set_bit = (op == op_set_bit);
	assign is_nonnull = (op == op_skip_if_nonnull);
	assign is_nonnull_bit = (op == op_skip_if_nonnull_bit);
	assign is_swap = (op == op_nibble_exchange);
	assign is_swap_tw = (op == op_nibble_exchange_to_work);
	assign is_null = (op == op_skip_if_null);
	assign is_null_tw = (op == op_skip_if_null_to_work);

	// operation groups
	logic any_sub;
	logic sub_uses_borrow;
	logic sub_uses_imm;
	logic any_dec;
	logic any_inc;
	logic any_null;

	assign sub_uses_borrow = is_sub_b | is_sub_b_imm | is_sub_b_mem;
	assign any_sub = sub_uses_borrow | is_sub | is_sub_imm | is_sub_mem;
	assign sub_uses_imm = is_sub_b_imm | is_sub_imm;
	assign any_dec = is_dec | is_dec_tw;
	assign any_inc = is_inc | is_inc_tw;
	assign any_null = is_null | is_null_tw;

	// subtract unit
	logic [DATA_W-1:0] sub_operand;
	logic sub_borrow_in;
	logic [DATA_W-1:0] sub_diff;
	logic sub_not_borrow;
	logic sub_half_not_borrow;
	logic sub_overflow;
	logic sub_zero;
	logic sub_sign_cmp;
	logic sub_multi_null;

	assign sub_operand = sub_uses_imm ? imm : mem_rdata;
	// plain subtract ignores the incoming flag
	assign sub_borrow_in = sub_uses_borrow ? ~bit_out_in : 1'b0;

	borrow_subtract #(
		.WIDTH(DATA_W)
	) u_sub (
		.minuend(work_q),
		.subtrahend(sub_operand),
		.borrow_in(sub_borrow_in),
		.diff(sub_diff),
		.not_borrow(sub_not_borrow),
		.half_not_borrow(sub_half_not_borrow),
		.overflow(sub_overflow)
	);

	assign sub_zero = (sub_diff == BYTE_ZERO);
	assign sub_sign_cmp = sub_overflow ^ sub_diff[MSB_POS];
	// borrow forms chain the zero test across bytes
	assign sub_multi_null = sub_uses_borrow ? (sub_zero & multibyte_null_in) : sub_zero;

	// per-operation results
	logic [DATA_W-1:0] rot_l_thru_val;
	logic [DATA_W-1:0] rot_r_val;
	logic [DATA_W-1:0] rot_r_thru_val;
	logic [DATA_W-1:0] dec_val;
	logic [DATA_W-1:0] inc_val;
	logic [DATA_W-1:0] swap_val;
	logic [DATA_W-1:0] bit_mask;
	logic [DATA_W-1:0] set_bit_val;
	logic sel_bit;
	logic mem_is_zero;

	assign rot_l_thru_val = {mem_rdata[MSB_POS-1:LSB_POS], bit_out_in};
	assign rot_r_val = {mem_rdata[LSB_POS], mem_rdata[MSB_POS:LSB_POS+1]};
	assign rot_r_thru_val = {bit_out_in, mem_rdata[MSB_POS:LSB_POS+1]};
	assign dec_val = mem_rdata - BYTE_ONE;
	assign inc_val = mem_rdata + BYTE_ONE;
	assign swap_val = {mem_rdata[NIBBLE_W-1:0], mem_rdata[DATA_W-1:NIBBLE_W]};
	// one-hot mask of the selected bit
	for (genvar gi = 0; gi < DATA_W; gi++) begin : g_bit_mask
		assign bit_mask[gi] = (bit_sel == BIT_SEL_W'(gi));
	end
	assign set_bit_val = mem_rdata | bit_mask;
	assign sel_bit = mem_rdata[bit_sel];
	assign mem_is_zero = (mem_rdata == BYTE_ZERO);

	// result selection
	logic [DATA_W-1:0] result;

	assign result = ({DATA_W{is_rot_l_tw}} & rot_l_thru_val)
		| ({DATA_W{is_rot_r | is_rot_r_tw}} & rot_r_val)
		| ({DATA_W{is_rot_rc | is_rot_rc_tw}} & rot_r_thru_val)
		| ({DATA_W{any_sub}} & sub_diff)
		| ({DATA_W{any_dec}} & dec_val)
		| ({DATA_W{any_inc}} & inc_val)
		| ({DATA_W{is_set_byte}} & BYTE_ONES)
		| ({DATA_W{is_set_bit}} & set_bit_val)
		| ({DATA_W{is_swap | is_swap_tw}} & swap_val)
		| ({DATA_W{is_null_tw}} & mem_rdata);

	// destination selection
	logic to_mem;
	logic to_work;

	assign to_mem = take & (is_rot_r | is_rot_rc | is_sub_b_mem | is_sub_mem
		| is_dec | is_inc | is_set_byte | is_set_bit | is_swap);
	// to-work forms leave memory alone
	assign to_work = take & (is_rot_l_tw | is_rot_r_tw | is_rot_rc_tw
		| is_sub_b | is_sub_b_imm | is_sub | is_sub_imm
		| is_dec_tw | is_inc_tw | is_swap_tw | is_null_tw);

	// skip conditions
	logic skip_cond;

	assign skip_cond = take & ((any_dec & (dec_val == BYTE_ZERO))
		| (any_inc & (inc_val == BYTE_ZERO))
		| (is_nonnull & ~mem_is_zero)
		| (is_nonnull_bit & sel_bit)
		| (any_null & mem_is_zero));

	// flag updates; rotates not through the flag, skips, sets and swaps touch none
	logic carry_rot_left;
	logic carry_rot_right;
	logic carry_we_d;
	logic arith_we_d;
	logic bit_out_src;

	assign carry_rot_left = take & is_rot_l_tw;
	assign carry_rot_right = take & (is_rot_rc | is_rot_rc_tw);
	assign arith_we_d = take & any_sub;
	assign carry_we_d = carry_rot_left | carry_rot_right | arith_we_d;
	assign bit_out_src = carry_rot_left ? mem_rdata[MSB_POS]
		: carry_rot_right ? mem_rdata[LSB_POS]
		: sub_not_borrow;

	// work register next value; an executed operation wins over a load
	assign work_d = to_work ? result : (work_load ? work_load_data : work_q);

	// write data holds between writes
	logic [DATA_W-1:0] mem_wdata_d;

	assign mem_wdata_d = to_mem ? result : mem_wdata_q;

	// flags hold unless their write pulse is due
	logic bit_out_d;
	logic overflow_d;
	logic zero_d;
	logic half_d;
	logic sign_cmp_d;
	logic multi_null_d;

	assign bit_out_d = carry_we_d ? bit_out_src : bit_out_q;
	assign overflow_d = arith_we_d ? sub_overflow : overflow_q;
	assign zero_d = arith_we_d ? sub_zero : zero_q;
	assign half_d = arith_we_d ? sub_half_not_borrow : half_q;
	assign sign_cmp_d = arith_we_d ? sub_sign_cmp : sign_cmp_q;
	assign multi_null_d = arith_we_d ? sub_multi_null : multi_null_q;

	// dummy slot after a taken skip
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			st_exec: begin
				if (skip_cond) begin
					state_d = st_dummy;
				end
			end
			st_dummy: begin
				state_d = st_exec;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= st_exec;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			skip_q <= FLAG_RESET;
		end else begin
			skip_q <= skip_cond;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			work_q <= WORK_RESET;
		end else begin
			work_q <= work_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_we_q <= FLAG_RESET;
		end else begin
			mem_we_q <= to_mem;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_wdata_q <= BYTE_ZERO;
		end else begin
			mem_wdata_q <= mem_wdata_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bit_out_we_q <= FLAG_RESET;
			bit_out_q <= FLAG_RESET;
		end else begin
			bit_out_we_q <= carry_we_d;
			bit_out_q <= bit_out_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			arith_we_q <= FLAG_RESET;
		end else begin
			arith_we_q <= arith_we_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			overflow_q <= FLAG_RESET;
			zero_q <= FLAG_RESET;
			half_q <= FLAG_RESET;
			sign_cmp_q <= FLAG_RESET;
			multi_null_q <= FLAG_RESET;
		end else begin
			overflow_q <= overflow_d;
			zero_q <= zero_d;
			half_q <= half_d;
			sign_cmp_q <= sign_cmp_d;
			multi_null_q <= multi_null_d;
		end
	end

	assign work_register = work_q;
	assign mem_we = mem_we_q;
	assign mem_wdata = mem_wdata_q;
	assign bit_out_we = bit_out_we_q;
	assign arith_flags_we = arith_we_q;
	assign bit_out_flag = bit_out_q;
	assign signed_overflow_flag = overflow_q;
	assign zero_flag = zero_q;
	assign half_nibble_flag = half_q;
	assign sign_compare_flag = sign_cmp_q;
	assign multibyte_null_flag = multi_null_q;
	assign skip = skip_q;
endmodule // mcu_rotate_sub_skip_datapath
`default_nettype wire

// [tb/datapath_props.sv]
// port assertions for the rotate, subtract and skip datapath
`timescale 1ns/10ps
`default_nettype none
module datapath_props
	import datapath_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic op_valid,
	input wire op_t op,
	input wire logic [DATA_W-1:0] mem_rdata,
	input wire logic bit_out_in,
	input wire logic op_ready,
	input wire logic [DATA_W-1:0] work_register,
	input wire logic mem_we,
	input wire logic [DATA_W-1:0] mem_wdata,
	input wire logic bit_out_we,
	input wire logic arith_flags_we,
	input wire logic bit_out_flag,
	input wire logic skip
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// an operation taken at this edge
	sequence s_take(op_t o);
		op_valid && op_ready && op == o;
	endsequence
	a_skip_dummy_slot: assert property (skip |-> !op_ready ##1 op_ready)
		else $error("dummy slot after skip wrong");
	a_rotate_right_mem: assert property (s_take(op_rotate_right) |=> mem_we && !bit_out_we
		&& mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
		else $error("plain rotate right wrong");
	a_rotate_thru_mem: assert property (s_take(op_rotate_right_thru_flag) |=> mem_we
		&& bit_out_we && bit_out_flag == $past(mem_rdata[0])
		&& mem_wdata == {$past(bit_out_in), $past(mem_rdata[7:1])})
		else $error("rotate through flag wrong");
	a_rotate_left_work: assert property (s_take(op_rotate_left_thru_flag_to_work) |=>
		!mem_we && bit_out_we && bit_out_flag == $past(mem_rdata[7])
		&& work_register == {$past(mem_rdata[6:0]), $past(bit_out_in)})
		else $error("rotate left to work wrong");
	a_set_byte_ones: assert property (s_take(op_set_byte) |=> mem_we
		&& mem_wdata == 8'hff && !arith_flags_we && !bit_out_we)
		else $error("set byte wrong");
	a_skip_null_test: assert property (s_take(op_skip_if_null) |=> !mem_we
		&& skip == ($past(mem_rdata) == 8'h00))
		else $error("skip if zero wrong");
	a_skip_nonnull_test: assert property (s_take(op_skip_if_nonnull) |=>
		skip == ($past(mem_rdata) != 8'h00))
		else $error("skip if nonzero wrong");
	a_swap_to_work: assert property (s_take(op_nibble_exchange_to_work) |=> !mem_we
		&& work_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
		else $error("nibble swap to work wrong");
	a_dec_skip_mem: assert property (s_take(op_dec_skip_zero) |=> mem_we && !bit_out_we
		&& mem_wdata == $past(mem_rdata) - 8'h01 && skip == ($past(mem_rdata) == 8'h01))
		else $error("decrement skip wrong");
	a_minus_flags: assert property (s_take(op_minus) |=> arith_flags_we && bit_out_we)
		else $error("subtract flag pulses missing");
endmodule // datapath_props
`default_nettype wire

// [tb/status_model.sv]
// status flag holder of the sequencer with bypass
`timescale 1ns/10ps
`default_nettype none
module status_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic bit_out_we,
	input wire logic arith_flags_we,
	input wire logic bit_out_flag,
	input wire logic multibyte_null_flag,
	output logic bit_out_in,
	output logic multibyte_null_in
);
	logic carry_q;
	logic mzero_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			carry_q <= 1'b0;
			mzero_q <= 1'b0;
		end else begin
			if (bit_out_we)
				carry_q <= bit_out_flag;
			if (arith_flags_we)
				mzero_q <= multibyte_null_flag;
		end
	end
	assign bit_out_in = bit_out_we ? bit_out_flag : carry_q;
	assign multibyte_null_in = arith_flags_we ? multibyte_null_flag : mzero_q;
endmodule // status_model
`default_nettype wire

// [tb/mcu_rotate_sub_skip_datapath_tb.sv]
// self-checking bench for the datapath
`timescale 1ns/10ps
`default_nettype none
module mcu_rotate_sub_skip_datapath_tb;
	import datapath_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic op_valid = 1'b0;
	op_t op = op_nop;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] imm = 8'h00;
	logic [2:0] bit_sel = 3'h0;
	logic work_load = 1'b0;
	logic [7:0] work_load_data = 8'h00;
	wire bit_out_in, multibyte_null_in, op_ready, mem_we, bit_out_we, arith_flags_we, skip;
	wire bit_out_flag, signed_overflow_flag, zero_flag, half_nibble_flag, sign_compare_flag;
	wire multibyte_null_flag;
	wire [7:0] work_register, mem_wdata;
	int failures = 0;
	int checks = 0;
	int w = 0;
	int c = 0;
	int mz = 0;
	always #4 clock = ~clock;
	mcu_rotate_sub_skip_datapath u_mcu_rotate_sub_skip_datapath (.clock(clock), .rst(rst),
		.op_valid(op_valid), .op(op), .mem_rdata(mem_rdata), .imm(imm), .bit_sel(bit_sel),
		.bit_out_in(bit_out_in), .multibyte_null_in(multibyte_null_in), .work_load(work_load),
		.work_load_data(work_load_data), .op_ready(op_ready), .work_register(work_register),
		.mem_we(mem_we), .mem_wdata(mem_wdata), .bit_out_we(bit_out_we),
		.arith_flags_we(arith_flags_we), .bit_out_flag(bit_out_flag),
		.signed_overflow_flag(signed_overflow_flag), .zero_flag(zero_flag),
		.half_nibble_flag(half_nibble_flag), .sign_compare_flag(sign_compare_flag),
		.multibyte_null_flag(multibyte_null_flag), .skip(skip));
	status_model u_status_model (.clock(clock), .rst(rst), .bit_out_we(bit_out_we),
		.arith_flags_we(arith_flags_we), .bit_out_flag(bit_out_flag),
		.multibyte_null_flag(multibyte_null_flag), .bit_out_in(bit_out_in),
		.multibyte_null_in(multibyte_null_in));
	task automatic stop_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input int exp, input string what);
		checks++;
		if (got !== 8'(exp)) begin
			failures++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp[7:0]);
		end
	endtask
	task automatic run(input op_t o);
		int m, x, b, opd, br, r, v, h, z, sk, cw, nc, tw, sub, subtract_with_borrow, sr, ov;
		logic [7:0] ld;
		m = $urandom_range(255);
		if ($urandom_range(3) == 0)
			m = $urandom_range(1) * ($urandom_range(1) ? 1 : 255);
		x = $urandom_range(255);
		b = $urandom_range(7);
		ld = 8'($urandom);
		op_valid = 1'b1;
		op = o;
		mem_rdata = m[7:0];
		imm = x[7:0];
		bit_sel = b[2:0];
		work_load = (o == op_nop);
		work_load_data = ld;
		subtract_with_borrow = o inside {op_subtract_with_borrow, op_subtract_with_borrow_imm,
			op_subtract_with_borrow_to_mem};
		sub = subtract_with_borrow || o inside {op_minus, op_minus_imm, op_minus_to_mem};
		opd = (o == op_subtract_with_borrow_imm || o == op_minus_imm) ? x : m;
		br = subtract_with_borrow ? 1 - c : 0;
		r = w - opd - br;
		h = (w & 15) - (opd & 15) - br >= 0;
		sr = (w > 127 ? w - 256 : w) - (opd > 127 ? opd - 256 : opd) - br;
		ov = sr < -128 || sr > 127;
		case (o)
			op_rotate_left_thru_flag_to_work: v = ((m << 1) | c) & 255;
			op_rotate_right, op_rotate_right_to_work: v = (m >> 1) | ((m & 1) << 7);
			op_rotate_right_thru_flag, op_rotate_right_thru_flag_to_work: v = (m >> 1) | (c << 7);
			op_dec_skip_zero, op_dec_skip_zero_to_work: v = (m + 255) & 255;
			op_inc_skip_zero, op_inc_skip_zero_to_work: v = (m + 1) & 255;
			op_set_byte: v = 255;
			op_set_bit: v = m | (1 << b);
			op_nibble_exchange, op_nibble_exchange_to_work: v = ((m & 15) << 4) | (m >> 4);
			op_skip_if_null_to_work: v = m;
			default: v = sub ? r & 255 : -1;
		endcase
		tw = o inside {op_rotate_left_thru_flag_to_work, op_rotate_right_to_work,
			op_rotate_right_thru_flag_to_work, op_subtract_with_borrow, op_minus, op_minus_imm,
			op_subtract_with_borrow_imm, op_dec_skip_zero_to_work, op_inc_skip_zero_to_work,
			op_nibble_exchange_to_work, op_skip_if_null_to_work};
		sk = (o inside {op_dec_skip_zero, op_dec_skip_zero_to_work, op_inc_skip_zero,
			op_inc_skip_zero_to_work} && v == 0) || (o == op_skip_if_nonnull && m != 0)
			|| (o inside {op_skip_if_null, op_skip_if_null_to_work} && m == 0)
			|| (o == op_skip_if_nonnull_bit && m[b]);
		cw = sub || o inside {op_rotate_left_thru_flag_to_work, op_rotate_right_thru_flag,
			op_rotate_right_thru_flag_to_work};
		nc = sub ? r >= 0 : (o == op_rotate_left_thru_flag_to_work ? m >> 7 : m & 1);
		@(posedge clock);
		#1;
		if (o == op_nop)
			w = ld;
		if (tw)
			w = v;
		chk(work_register, w, "work");
		chk(mem_we, v >= 0 && !tw, "mem write");
		if (v >= 0 && !tw)
			chk(mem_wdata, v, "mem data");
		chk(skip, sk, "skip");
		chk(op_ready, !sk, "ready");
		chk(arith_flags_we, sub, "flag pulse");
		chk(bit_out_we, cw, "bit-out pulse");
		if (cw)
			chk(bit_out_flag, nc, "bit-out");
		if (cw)
			c = nc;
		if (sub) begin
			z = (r & 255) == 0;
			mz = subtract_with_borrow ? z & mz : z;
			chk(zero_flag, z, "zero");
			chk(half_nibble_flag, h, "half");
			chk(signed_overflow_flag, ov, "overflow");
			chk(sign_compare_flag, ov ^ ((r & 255) >> 7), "sign compare");
			chk(multibyte_null_flag, mz, "multibyte");
		end
		if (sk) begin
			op = op_set_byte;
			@(posedge clock);
			#1;
			chk(mem_we, 0, "refused op");
		end
	endtask
	initial begin
		void'($urandom(32'h27a358bb));
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		chk(op_ready, 1, "reset ready");
		for (int i = 0; i < 24; i++)
			run(op_t'(i));
		repeat (400) run(op_t'($urandom_range(23)));
		op_valid = 1'b0;
		stop_test;
	end
	initial begin
		#100000;
		failures++;
		stop_test;
	end
endmodule // mcu_rotate_sub_skip_datapath_tb
bind mcu_rotate_sub_skip_datapath datapath_props u_datapath_props (.clock(clock), .rst(rst),
	.op_valid(op_valid), .op(op), .mem_rdata(mem_rdata), .bit_out_in(bit_out_in),
	.op_ready(op_ready), .work_register(work_register), .mem_we(mem_we), .mem_wdata(mem_wdata),
	.bit_out_we(bit_out_we), .arith_flags_we(arith_flags_we), .bit_out_flag(bit_out_flag),
	.skip(skip));
`default_nettype wire
